// [rtl/mcfi_pkg.sv]
// constants and types for the motion command frame interpreter
// Notes on behaviour
// [RULE1] never transmit unprompted; every reply answers a received command frame
// [RULE2] keep the transceiver receiving except while a reply is being sent
// [RULE3] after executing a host command send exactly one reply frame
// [RULE4] host waits for the full reply before sending its next command
// [RULE5] command core is command, type, selector and four value bytes
// [RULE6] serial links wrap the core with an address byte and a checksum byte
// [RULE7] frame order: address, command, type, selector, value MSB first, checksum
// [RULE8] command checksum is the 8-bit sum of all earlier frame bytes
// [RULE9] on CAN there is no address or checksum byte in commands
// [RULE10] reply order: reply address, module address, status, command, value, checksum
// [RULE11] reply checksum is the 8-bit sum of all other reply bytes
// [RULE12] on CAN the reply drops its address and checksum bytes
// [RULE13] status 100 for executed, 101 for stored into program memory
// [RULE14] error statuses 1 to 6 for checksum, command, type, value, lock, unavailable
// [RULE15] stored command sequences also run from local memory without a host
// [RULE16] serial frames for another module address are dropped without reply
package mcfi_pkg;
  localparam int unsigned FIFO_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  // command frame byte positions
  localparam logic [3:0] IDX_ADDR = 4'h0;
  localparam logic [3:0] IDX_CMD  = 4'h1;
  localparam logic [3:0] IDX_TYPE = 4'h2;
  localparam logic [3:0] IDX_BANK = 4'h3;
  localparam logic [3:0] IDX_V3   = 4'h4;
  localparam logic [3:0] IDX_V0   = 4'h7;
  localparam logic [3:0] IDX_SUM  = 4'h8;
  // reply frame byte positions
  localparam logic [3:0] R_RADDR  = 4'h0;
  localparam logic [3:0] R_MADDR  = 4'h1;
  localparam logic [3:0] R_STAT   = 4'h2;
  localparam logic [3:0] R_CMD    = 4'h3;
  localparam logic [3:0] R_V3     = 4'h4;
  localparam logic [3:0] R_V2     = 4'h5;
  localparam logic [3:0] R_V1     = 4'h6;
  localparam logic [3:0] R_V0     = 4'h7;
  localparam logic [3:0] R_SUM    = 4'h8;
  // reply lengths in bytes
  localparam logic [3:0] SER_LEN  = 4'h9;
  localparam logic [3:0] CAN_LEN  = 4'h6;
  // status codes
  localparam logic [7:0] ST_OK      = 8'h64;
  localparam logic [7:0] ST_STORED  = 8'h65;
  localparam logic [7:0] ST_BADSUM  = 8'h01;
  localparam logic [7:0] ST_BADCMD  = 8'h02;
  localparam logic [7:0] ST_BADTYPE = 8'h03;
  localparam logic [7:0] ST_BADVAL  = 8'h04;
  localparam logic [7:0] ST_LOCKED  = 8'h05;
  localparam logic [7:0] ST_NOCMD   = 8'h06;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] value;
  } cmd_core_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [31:0] value;
  } exec_res_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_EXEC  = 3'b010,
    S_REPLY = 3'b100
  } state_t;
endpackage : mcfi_pkg

// [rtl/motion_command_frame_interpreter.sv]
// command frame interpreter with reply fifo
`timescale 1ns/10ps

module reply_fifo
#(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
)
(
  // clock
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          do_wr;
  logic          do_rd;

  assign in_ready  = (count < (AW+1)'(D));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign do_wr     = ce && in_valid && in_ready;
  assign do_rd     = ce && out_valid && out_ready;

  always_ff @(posedge core_clk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
      end
      case ({do_wr, do_rd})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule : reply_fifo

module motion_command_frame_interpreter
  import mcfi_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  // configuration
  input  wire logic       link_is_can,
  input  wire logic [7:0] own_addr,
  input  wire logic [7:0] reply_addr,
  // received bytes
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_sof,
  // transmitted bytes
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  input  wire logic       tx_ready,
  output logic            tx_enable,
  // stored program commands
  input  wire logic       prog_valid,
  output logic            prog_ready,
  input  wire cmd_core_t  prog_cmd,
  // command executor
  output logic            exec_valid,
  output cmd_core_t       exec_cmd,
  input  wire logic       exec_done,
  input  wire exec_res_t  exec_res
);
  function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
    add8 = 8'(a + b);
  endfunction : add8

  state_t     state;
  logic       lc1;
  logic       lc2;
  logic       lc3;
  logic       can;
  logic [3:0] pos;
  logic [7:0] rx_sum;
  logic [7:0] rx_addr;
  logic       frame_ready;
  logic       frm_bad;
  cmd_core_t  frm;
  logic       src_host;
  logic [7:0] rep_status;
  logic [7:0] rep_cmd;
  logic [31:0] rep_value;
  logic [3:0] tidx;
  logic [7:0] tsum;
  logic [7:0] rep_byte;
  logic       rep_last;
  logic       push;
  logic       take_prog;
  logic       take_host;
  logic       rx_last;
  logic       f_in_ready;
  logic       f_out_valid;
  logic       f_out_ready;
  logic [7:0] f_out_data;
  logic [3:0] rep_cnt;
  logic       mode_chg;

  // link mode pin synchroniser
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      lc1 <= 1'b0;
      lc2 <= 1'b0;
      lc3 <= 1'b0;
      can <= 1'b0;
    end
    else if (ce)
    begin
      lc1 <= link_is_can;
      lc2 <= lc1;
      lc3 <= lc2;
      if (lc2 == lc3)
      begin
        can <= lc3;
      end
    end
  end

  // realign the byte counter when the link mode flips
  assign mode_chg  = ce && (lc2 == lc3) && (lc3 != can);

  // [RULE6] serial frames end at checksum
  assign rx_last   = can ? (pos == IDX_V0) : (pos == IDX_SUM);
  assign take_prog = (state == S_IDLE) && prog_valid && prog_ready;
  assign take_host = (state == S_IDLE) && !take_prog && frame_ready;

  // frame receiver
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      pos         <= IDX_ADDR;
      rx_sum      <= '0;
      rx_addr     <= '0;
      frame_ready <= 1'b0;
      frm_bad     <= 1'b0;
      frm         <= '0;
    end
    else if (ce)
    begin
      if (take_host)
      begin
        frame_ready <= 1'b0;
      end
      if (rx_sof || mode_chg)
      begin
        pos    <= (mode_chg ? lc3 : can) ? IDX_CMD : IDX_ADDR;
        rx_sum <= '0;
      end
      else if (rx_valid && !frame_ready)
      begin
        // [RULE8] running 8-bit sum
        rx_sum <= add8(rx_sum, rx_data);
        pos    <= pos + 1'b1;
        // [RULE7] byte order, value MSB first
        case (pos)
          IDX_ADDR: rx_addr  <= rx_data;
          IDX_CMD:  frm.cmd  <= rx_data;
          IDX_TYPE: frm.typ  <= rx_data;
          IDX_BANK: frm.bank <= rx_data;
          IDX_SUM:  ;
          default:  frm.value <= {frm.value[23:0], rx_data};
        endcase
        if (rx_last)
        begin
          // [RULE9] CAN frames start at command
          pos    <= can ? IDX_CMD : IDX_ADDR;
          rx_sum <= '0;
          // [RULE16] drop foreign address
          if (can || rx_addr == own_addr)
          begin
            frame_ready <= 1'b1;
            frm_bad     <= !can && (rx_data != rx_sum);
          end
        end
      end
    end
  end

  // command sequencing
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state      <= S_IDLE;
      exec_valid <= 1'b0;
      exec_cmd   <= '0;
      src_host   <= 1'b0;
      prog_ready <= 1'b0;
      rep_status <= '0;
      rep_cmd    <= '0;
      rep_value  <= '0;
    end
    else if (ce)
    begin
      exec_valid <= 1'b0;
      case (state)
        S_IDLE:
        begin
          prog_ready <= !frame_ready;
          // [RULE15] stored command runs without reply
          if (take_prog)
          begin
            exec_valid <= 1'b1;
            exec_cmd   <= prog_cmd;
            src_host   <= 1'b0;
            prog_ready <= 1'b0;
            state      <= S_EXEC;
          end
          else if (take_host)
          begin
            src_host   <= 1'b1;
            rep_cmd    <= frm.cmd;
            prog_ready <= 1'b0;
            // [RULE14] bad checksum answered directly
            if (frm_bad)
            begin
              rep_status <= ST_BADSUM;
              rep_value  <= '0;
              state      <= S_REPLY;
            end
            else
            begin
              // [RULE5] seven byte core to executor
              exec_valid <= 1'b1;
              exec_cmd   <= frm;
              state      <= S_EXEC;
            end
          end
        end
        S_EXEC:
        begin
          if (exec_done)
          begin
            // [RULE1] reply only for host frames
            if (src_host)
            begin
              // [RULE13] executor status passed back
              rep_status <= exec_res.status;
              rep_value  <= exec_res.value;
              state      <= S_REPLY;
            end
            else
            begin
              state <= S_IDLE;
            end
          end
        end
        S_REPLY:
        begin
          // [RULE3] one reply then idle
          if (push && rep_last)
          begin
            state      <= S_IDLE;
            prog_ready <= !frame_ready;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // [RULE12] CAN reply is status to value
  assign rep_last = can ? (tidx == R_V0) : (tidx == R_SUM);
  assign push     = (state == S_REPLY) && f_in_ready;

  // [RULE10] reply byte order
  always_comb
  begin
    case (tidx)
      R_RADDR: rep_byte = reply_addr;
      R_MADDR: rep_byte = own_addr;
      R_STAT:  rep_byte = rep_status;
      R_CMD:   rep_byte = rep_cmd;
      R_V3:    rep_byte = rep_value[31:24];
      R_V2:    rep_byte = rep_value[23:16];
      R_V1:    rep_byte = rep_value[15:8];
      R_V0:    rep_byte = rep_value[7:0];
      R_SUM:   rep_byte = tsum;
      default: rep_byte = '0;
    endcase
  end

  // reply builder
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      tidx    <= R_RADDR;
      tsum    <= '0;
      rep_cnt <= '0;
    end
    else if (ce)
    begin
      if (state != S_REPLY)
      begin
        tidx    <= can ? R_STAT : R_RADDR;
        tsum    <= '0;
        rep_cnt <= '0;
      end
      else if (push)
      begin
        tidx    <= tidx + 1'b1;
        rep_cnt <= rep_cnt + 1'b1;
        // [RULE11] reply sum
        tsum    <= add8(tsum, rep_byte);
      end
    end
  end

  reply_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo
  (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .ce        (ce),
    .in_valid  (state == S_REPLY),
    .in_ready  (f_in_ready),
    .in_data   (rep_byte),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  assign f_out_ready = !tx_valid || tx_ready;

  // output byte stage
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      tx_valid <= 1'b0;
      tx_data  <= '0;
    end
    else if (ce && f_out_ready)
    begin
      tx_valid <= f_out_valid;
      tx_data  <= f_out_data;
    end
  end

  // [RULE2] driver on only around a reply
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      tx_enable <= 1'b0;
    end
    else if (ce)
    begin
      if (state == S_REPLY)
      begin
        tx_enable <= 1'b1;
      end
      else if (!f_out_valid && !tx_valid)
      begin
        tx_enable <= 1'b0;
      end
    end
  end

  a_tx_needs_enable: assert property ( // [RULE2]
    @(posedge core_clk) disable iff (!resetn) tx_valid |-> tx_enable)
    else $error("byte offered with driver off");

  a_reply_host_only: assert property ( // [RULE1]
    @(posedge core_clk) disable iff (!resetn) (state == S_REPLY) |-> src_host)
    else $error("reply without host command");

  a_reply_length: assert property ( // [RULE3]
    @(posedge core_clk) disable iff (!resetn)
    (ce && push && rep_last) |-> (rep_cnt == (can ? CAN_LEN : SER_LEN) - 4'h1))
    else $error("reply length wrong");

  a_reply_sum_last: assert property ( // [RULE11]
    @(posedge core_clk) disable iff (!resetn)
    (push && !can && tidx == R_SUM) |->
    (rep_byte == 8'(reply_addr + own_addr + rep_status + rep_cmd + rep_value[31:24]
                    + rep_value[23:16] + rep_value[15:8] + rep_value[7:0])))
    else $error("reply checksum byte wrong");

  a_badsum_status: assert property ( // [RULE14]
    @(posedge core_clk) disable iff (!resetn)
    (ce && take_host && frm_bad) |=> (state == S_REPLY && rep_status == ST_BADSUM))
    else $error("bad checksum not reported");

  a_foreign_dropped: assert property ( // [RULE16]
    @(posedge core_clk) disable iff (!resetn)
    (ce && rx_valid && !rx_sof && !frame_ready && rx_last && !can && rx_addr != own_addr)
    |=> !frame_ready)
    else $error("foreign frame accepted");

  a_can_reply_start: assert property ( // [RULE12]
    @(posedge core_clk) disable iff (!resetn)
    (state == S_REPLY && can && rep_cnt == 4'h0) |-> (tidx == R_STAT))
    else $error("CAN reply carries address");

  a_exec_core_copy: assert property ( // [RULE5]
    @(posedge core_clk) disable iff (!resetn)
    (ce && take_host && !frm_bad) |=> (exec_valid && exec_cmd == $past(frm)))
    else $error("core not forwarded");

  a_stored_silent: assert property ( // [RULE15]
    @(posedge core_clk) disable iff (!resetn)
    (ce && take_prog) |=> (state == S_EXEC && !src_host))
    else $error("stored command marked for reply");
endmodule : motion_command_frame_interpreter

// [tb/mcfi_host.sv]
// host bus master model: sends frames, collects reply bytes
`timescale 1ns/10ps

module mcfi_host
(
  // clock
  input  wire logic       core_clk,
  // link from host
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_sof,
  // link to host
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  input  wire logic       tx_enable
);
  logic [7:0] got[$];
  logic       slow;
  logic       tx_seen;
  logic [3:0] cyc;

  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_sof   = 1'b0;
    tx_ready = 1'b0;
    slow     = 1'b0;
    tx_seen  = 1'b0;
    cyc      = 4'h0;
  end

  task automatic send(input logic [71:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_data  <= f[71-8*i -: 8];
    end
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask : send

  // one-cycle frame restart pulse
  task automatic resync();
    @(posedge core_clk);
    rx_sof <= 1'b1;
    @(posedge core_clk);
    rx_sof <= 1'b0;
  endtask : resync

  // collect replies, stalling every other pair of cycles when slow
  always @(posedge core_clk)
  begin
    cyc <= cyc + 4'h1;
    tx_ready <= slow ? cyc[1] : 1'b1;
    if (tx_enable)
      tx_seen <= 1'b1;
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
  end
endmodule : mcfi_host

// [tb/test_motion_command_frame_interpreter.sv]
// testbench for the motion command frame interpreter
`timescale 1ns/10ps

`define check(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end

module test_motion_command_frame_interpreter
  import mcfi_pkg::*;
;
  logic      core_clk, resetn, link_is_can, prog_valid, exec_done;
  logic      rx_valid, rx_sof, tx_valid, tx_ready, tx_enable, prog_ready, exec_valid;
  logic [7:0] own_addr, reply_addr, rx_data, tx_data;
  cmd_core_t prog_cmd, exec_cmd;
  exec_res_t exec_res, res_cfg;
  int        num_errors, checks, n_exec, cycles;
  logic [1:0] dly;

  motion_command_frame_interpreter i_motion_command_frame_interpreter (
    .core_clk(core_clk), .resetn(resetn), .ce(1'b1), .link_is_can(link_is_can),
    .own_addr(own_addr), .reply_addr(reply_addr), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_sof(rx_sof), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .tx_enable(tx_enable), .prog_valid(prog_valid),
    .prog_ready(prog_ready), .prog_cmd(prog_cmd), .exec_valid(exec_valid),
    .exec_cmd(exec_cmd), .exec_done(exec_done), .exec_res(exec_res));

  mcfi_host i_mcfi_host (
    .core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .tx_enable(tx_enable));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // executor answers four cycles after each start
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (exec_valid)
      n_exec <= n_exec + 1;
    dly       <= exec_valid ? 2'h3 : (dly != 2'h0 ? dly - 2'h1 : 2'h0);
    exec_done <= (dly == 2'h1);
    exec_res  <= (dly == 2'h1) ? res_cfg : ~res_cfg;
    if (cycles == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // waits for the reply and the return to receive mode, then compares it
  task automatic check_reply(input logic [71:0] e, input int n);
    int t;
    t = 0;
    // next frame only after the full reply
    while ((i_mcfi_host.got.size() < n || tx_enable !== 1'b0) && t < 400)
    begin
      @(posedge core_clk);
      t++;
    end
    repeat (20) @(posedge core_clk);
    `check(i_mcfi_host.got.size(), n)
    for (int i = 0; i < n && i < i_mcfi_host.got.size(); i++)
      `check(i_mcfi_host.got[i], e[71-8*i -: 8])
    `check(tx_enable, 1'b0)
    i_mcfi_host.got.delete();
  endtask : check_reply

  task automatic serial_cmd(input cmd_core_t c, input logic [7:0] st, input logic good);
    logic [63:0] b;
    logic [7:0]  s, r;
    int          n0;
    b  = {own_addr, c};
    s  = 8'h00;
    n0 = n_exec;
    for (int i = 0; i < 8; i++)
      s = s + b[63-8*i -: 8];
    res_cfg = '{status: st, value: ~c.value};
    i_mcfi_host.send({b, good ? s : s + 8'h01}, 9);
    b = {reply_addr, own_addr, (good ? st : ST_BADSUM), c.cmd, (good ? ~c.value : 32'h0)};
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r = r + b[63-8*i -: 8];
    check_reply({b, r}, 9);
    `check(n_exec - n0, good ? 1 : 0)
    if (good)
      `check(exec_cmd, c)
  endtask : serial_cmd

  // all executor statuses, stalled and prompt transmitter
  task automatic test_status_codes();
    logic [7:0] sts[7] = '{ST_OK, ST_STORED, ST_BADCMD, ST_BADTYPE, ST_BADVAL,
                           ST_LOCKED, ST_NOCMD};
    for (int i = 0; i < 7; i++)
    begin
      i_mcfi_host.slow = i[0];
      serial_cmd('{cmd: 8'h04 + i[7:0], typ: 8'h01, bank: 8'h02, value: 32'h8a0b0c0d}, sts[i], 1'b1);
    end
    i_mcfi_host.slow = 1'b0;
  endtask : test_status_codes

  task automatic test_bad_sum();
    serial_cmd('{cmd: 8'h06, typ: 8'hff, bank: 8'h00, value: 32'hfffffff0}, ST_OK, 1'b0);
  endtask : test_bad_sum

  task automatic test_other_addr();
    int n0;
    n0 = n_exec;
    i_mcfi_host.send({own_addr + 8'h01, 64'h0501020000000100}, 9);
    repeat (60) @(posedge core_clk);
    `check(i_mcfi_host.got.size(), 0)
    `check(i_mcfi_host.tx_seen, 1'b0)
    `check(n_exec - n0, 0)
  endtask : test_other_addr

  task automatic test_can();
    cmd_core_t c;
    c = '{cmd: 8'h0a, typ: 8'h40, bank: 8'h01, value: 32'h01020304};
    res_cfg = '{status: ST_OK, value: 32'hf0e0d0c0};
    link_is_can <= 1'b1;
    repeat (6) @(posedge core_clk);
    i_mcfi_host.send({c, 16'h0000}, 7);
    check_reply({ST_OK, c.cmd, 32'hf0e0d0c0, 24'h0}, 6);
    `check(exec_cmd, c)
    link_is_can <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask : test_can

  // stray bytes, restart pulse, then a clean frame
  task automatic test_resync();
    i_mcfi_host.send({24'h030405, 48'h0}, 3);
    i_mcfi_host.resync();
    serial_cmd('{cmd: 8'h05, typ: 8'h04, bank: 8'h00, value: 32'h00001234}, ST_OK, 1'b1);
  endtask : test_resync

  task automatic test_program();
    int n0, t;
    n0 = n_exec;
    t  = 0;
    prog_cmd   <= '{cmd: 8'h16, typ: 8'h00, bank: 8'h00, value: 32'h00000007};
    prog_valid <= 1'b1;
    @(posedge core_clk);
    while (!(prog_valid && prog_ready) && t < 50)
    begin
      @(posedge core_clk);
      t++;
    end
    prog_valid <= 1'b0;
    repeat (40) @(posedge core_clk);
    `check(n_exec - n0, 1)
    `check(exec_cmd, prog_cmd)
    `check(i_mcfi_host.got.size(), 0)
  endtask : test_program

  initial
  begin
    resetn      = 1'b0;
    link_is_can = 1'b0;
    own_addr    = 8'h03;
    reply_addr  = 8'h02;
    prog_valid  = 1'b0;
    prog_cmd    = '0;
    exec_done   = 1'b0;
    exec_res    = '0;
    res_cfg     = '0;
    dly         = 2'h0;
    num_errors  = 0;
    checks      = 0;
    n_exec      = 0;
    cycles      = 0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (30) @(posedge core_clk);
    `check(tx_enable, 1'b0)
    test_other_addr();
    test_status_codes();
    test_bad_sum();
    test_resync();
    test_can();
    test_program();
    own_addr <= 8'hfe;
    @(posedge core_clk);
    serial_cmd('{cmd: 8'hff, typ: 8'h80, bank: 8'h7f, value: 32'h80000001}, ST_OK, 1'b1);
    stop_test();
  end
endmodule : test_motion_command_frame_interpreter
